// File: hw/gpb_bank.sv
// apb slave holding port 3/5 pin data, per-pin masks and change events
`timescale 1ns/1ps
`default_nettype none

module gpb_bank (
  // clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [gpb_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [gpb_pkg::DATA_W-1:0]   pwdata,
  output logic      [gpb_pkg::DATA_W-1:0]   prdata,
  output logic                              pready,
  output logic                              pslverr,
  // port 3 and port 5 pins
  input  wire logic [gpb_pkg::PIN_W-1:0]    p3_in,
  output gpb_pkg::gpb_drive_t               p3_drive,
  input  wire logic [gpb_pkg::PIN_W-1:0]    p5_in,
  output gpb_pkg::gpb_drive_t               p5_drive,
  // masks for ports served elsewhere in the unit
  output logic      [gpb_pkg::PIN_W-1:0]    p1_mask,
  output logic      [gpb_pkg::PIN_W-1:0]    p2_mask,
  // interrupt
  output logic                              irq
);

  logic [7:0]  p3_level_reg, p5_level_reg;
  logic [7:0]  p1_mask_reg, p2_mask_reg, p3_mask_reg, p5_mask_reg;
  logic [7:0]  p3_dir_reg, p5_dir_reg;
  logic [15:0] status_reg, irq_en_reg;
  logic [15:0] sync1_reg, sync2_reg, prev_reg;
  logic [2:0]  settle_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg, pslverr_reg, irq_reg;

  // pin synchronisers, one per pin
  wire [15:0] pin_raw = {p5_in, p3_in};
  genvar gi;
  generate
    for (gi = 0; gi < gpb_pkg::EVT_W; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          prev_reg[gi]  <= 1'b0;
        end else begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          prev_reg[gi]  <= sync2_reg[gi];
        end
      end
    end
  endgenerate

  // edges before the pipeline fills are reset artefacts, not pin changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) settle_reg <= 3'h0;
    else settle_reg <= {settle_reg[1:0], 1'b1};
  end
  wire armed = settle_reg[gpb_pkg::SETTLE_CYC-1];

  // address decode
  wire [9:0] widx   = paddr[11:2];
  wire hit_p3l = (widx == {2'h0, gpb_pkg::IDX_P3_LEVEL});
  wire hit_p5l = (widx == {2'h0, gpb_pkg::IDX_P5_LEVEL});
  wire hit_m1  = (widx == {2'h0, gpb_pkg::IDX_P1_MASK});
  wire hit_m2  = (widx == {2'h0, gpb_pkg::IDX_P2_MASK});
  wire hit_m3  = (widx == {2'h0, gpb_pkg::IDX_P3_MASK});
  wire hit_m5  = (widx == {2'h0, gpb_pkg::IDX_P5_MASK});
  wire hit_sts = (widx == {2'h0, gpb_pkg::IDX_STATUS});
  wire hit_ien = (widx == {2'h0, gpb_pkg::IDX_IRQ_EN});
  wire hit_d3  = (widx == {2'h0, gpb_pkg::IDX_P3_DIR});
  wire hit_d5  = (widx == {2'h0, gpb_pkg::IDX_P5_DIR});
  wire mapped  = hit_p3l | hit_p5l | hit_m1 | hit_m2 | hit_m3 | hit_m5
               | hit_sts | hit_ien | hit_d3 | hit_d5;

  wire setup = psel & ~penable;
  // writes commit only on the completing edge; unmapped writes are dropped
  wire wr    = psel & penable & pready_reg & pwrite & mapped;

  // register next values
  wire [7:0] p3_level_next = (wr & hit_p3l) ? pwdata[7:0] : p3_level_reg;
  wire [7:0] p5_level_next = (wr & hit_p5l) ? pwdata[7:0] : p5_level_reg;
  wire [7:0] p1_mask_next  = (wr & hit_m1) ? pwdata[7:0] : p1_mask_reg;
  wire [7:0] p2_mask_next  = (wr & hit_m2) ? pwdata[7:0] : p2_mask_reg;
  wire [7:0] p3_mask_next  = (wr & hit_m3) ? pwdata[7:0] : p3_mask_reg;
  wire [7:0] p5_mask_next  = (wr & hit_m5) ? pwdata[7:0] : p5_mask_reg;
  wire [7:0] p3_dir_next   = (wr & hit_d3) ? pwdata[7:0] : p3_dir_reg;
  wire [7:0] p5_dir_next   = (wr & hit_d5) ? pwdata[7:0] : p5_dir_reg;
  wire [15:0] irq_en_next  = (wr & hit_ien) ? pwdata[15:0] : irq_en_reg;

  // change events on input pins; outputs would only echo our own writes
  wire [15:0] dir16  = {p5_dir_reg, p3_dir_reg};
  wire [15:0] mask16 = {p5_mask_reg, p3_mask_reg};
  wire [15:0] chg_set = (sync2_reg ^ prev_reg) & ~dir16 & ~mask16 & {16{armed}};
  wire [15:0] w1c     = (wr & hit_sts) ? pwdata[15:0] : gpb_pkg::RST_HALF;
  // a new event in the clearing cycle survives
  wire [15:0] status_next = (status_reg & ~w1c) | chg_set;
  wire        irq_next    = |(status_next & irq_en_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p3_level_reg <= gpb_pkg::RST_BYTE;
      p5_level_reg <= gpb_pkg::RST_BYTE;
      p1_mask_reg  <= gpb_pkg::RST_BYTE;
      p2_mask_reg  <= gpb_pkg::RST_BYTE;
      p3_mask_reg  <= gpb_pkg::RST_BYTE;
      p5_mask_reg  <= gpb_pkg::RST_BYTE;
    end else begin
      p3_level_reg <= p3_level_next;
      p5_level_reg <= p5_level_next;
      p1_mask_reg  <= p1_mask_next;
      p2_mask_reg  <= p2_mask_next;
      p3_mask_reg  <= p3_mask_next;
      p5_mask_reg  <= p5_mask_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p3_dir_reg <= gpb_pkg::RST_BYTE;
      p5_dir_reg <= gpb_pkg::RST_BYTE;
      irq_en_reg <= gpb_pkg::RST_HALF;
      status_reg <= gpb_pkg::RST_HALF;
      irq_reg    <= 1'b0;
    end else begin
      p3_dir_reg <= p3_dir_next;
      p5_dir_reg <= p5_dir_next;
      irq_en_reg <= irq_en_next;
      status_reg <= status_next;
      irq_reg    <= irq_next;
    end
  end

  // read path: input pins show the synchronised level, outputs the latch
  wire [15:0] lvl16 = {p5_level_reg, p3_level_reg};
  wire [15:0] rd_level = (~dir16 & sync2_reg) | (dir16 & lvl16);
  wire [7:0] rd_byte =
      hit_p3l ? rd_level[gpb_pkg::EVT_P3_LSB +: 8] :
      hit_p5l ? rd_level[gpb_pkg::EVT_P5_LSB +: 8] :
      hit_m1  ? p1_mask_reg :
      hit_m2  ? p2_mask_reg :
      hit_m3  ? p3_mask_reg :
      hit_m5  ? p5_mask_reg :
      hit_d3  ? p3_dir_reg  :
      hit_d5  ? p5_dir_reg  : gpb_pkg::RST_BYTE;
  wire [15:0] rd_half = hit_sts ? status_reg : (hit_ien ? irq_en_reg : {8'h00, rd_byte});
  wire [31:0] rd_word = {16'h0000, rd_half};

  // one access cycle per transfer: data is sampled in the setup cycle
  wire        pready_next  = setup & ~pready_reg;
  wire        pslverr_next = setup & ~mapped;
  wire [31:0] prdata_next  = setup ? ((~pwrite & mapped) ? rd_word : 32'h0000_0000) : prdata_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg  <= prdata_next;
    end
  end

  assign prdata   = prdata_reg;
  assign pready   = pready_reg;
  assign pslverr  = pslverr_reg;
  assign p3_drive = '{out: p3_level_reg, oe: p3_dir_reg};
  assign p5_drive = '{out: p5_level_reg, oe: p5_dir_reg};
  assign p1_mask  = p1_mask_reg;
  assign p2_mask  = p2_mask_reg;
  assign irq      = irq_reg;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire rd_setup = setup & ~pwrite;

  a_input_level_read: assert property (
    rd_setup & hit_p3l |=> ((prdata[7:0] ^ $past(sync2_reg[7:0])) & ~$past(p3_dir_reg)) == 8'h00)
    else $error("input pin level not returned on read");

  a_p3_out_drive: assert property (
    wr & hit_p3l |=> p3_drive.out == $past(pwdata[7:0]))
    else $error("port 3 drive did not follow write");

  a_p3_output_read: assert property (
    rd_setup & hit_p3l |=> ((prdata[7:0] ^ p3_level_reg) & p3_dir_reg) == 8'h00)
    else $error("port 3 output bits not read back from latch");

  a_p5_out_drive: assert property (
    wr & hit_p5l |=> p5_drive.out == $past(pwdata[7:0]) ##1 p5_drive.out == $past(p5_drive.out))
    else $error("port 5 drive wrong after write");

  a_p1_mask_write: assert property (
    wr & hit_m1 |=> p1_mask == $past(pwdata[7:0]))
    else $error("port 1 mask not written");

  a_p2_mask_write: assert property (
    wr & hit_m2 |=> p2_mask == $past(pwdata[7:0]))
    else $error("port 2 mask not written");

  a_p3_mask_read: assert property (
    rd_setup & hit_m3 |=> pready && prdata == {24'h00_0000, $past(p3_mask_reg)})
    else $error("port 3 mask read wrong");

  a_p5_mask_read: assert property (
    rd_setup & hit_m5 |=> pready && prdata == {24'h00_0000, $past(p5_mask_reg)})
    else $error("port 5 mask read wrong");

  a_reset_zero: assert property (@(posedge pclk) disable iff (1'b0)
    $rose(presetn) |-> p3_level_reg == 8'h00 && p5_level_reg == 8'h00 && p1_mask_reg == 8'h00
                       && p2_mask_reg == 8'h00 && p3_mask_reg == 8'h00 && p5_mask_reg == 8'h00)
    else $error("bank registers not zero after reset");

  a_masked_no_event: assert property (
    $rose(status_reg[0]) |-> $past(!p3_mask_reg[0]) && $past(!p3_dir_reg[0]) && $past(sync2_reg[0] != prev_reg[0]))
    else $error("event raised by masked or output pin");

  a_one_access_cycle: assert property (
    setup |=> pready ##1 !pready)
    else $error("access phase not exactly one cycle");

  a_irq_level: assert property (
    ##1 irq == |(status_reg & $past(irq_en_reg)))
    else $error("irq does not follow unmasked status");

  // read path checks, port 5 side
  a_p5_input_read: assert property (
    rd_setup & hit_p5l |=> ((prdata[7:0] ^ $past(sync2_reg[15:8])) & ~$past(p5_dir_reg)) == 8'h00)
    else $error("port 5 input level not returned on read");

  a_p5_output_read: assert property (
    rd_setup & hit_p5l |=> ((prdata[7:0] ^ $past(p5_level_reg)) & $past(p5_dir_reg)) == 8'h00)
    else $error("port 5 output bits not read back from latch");

  // drive checks: enables follow their writes, levels move only on writes
  a_p3_enable_drive: assert property (
    wr & hit_d3 |=> p3_drive.oe == $past(pwdata[7:0]))
    else $error("port 3 output enable did not follow write");

  a_p5_enable_drive: assert property (
    wr & hit_d5 |=> p5_drive.oe == $past(pwdata[7:0]))
    else $error("port 5 output enable did not follow write");

  a_drive_holds: assert property (
    !(wr & (hit_p3l | hit_p5l)) |=> $stable({p3_drive.out, p5_drive.out}))
    else $error("pin drive changed without a data write");

  // mask registers: every one written and read back
  a_p1_mask_read: assert property (
    rd_setup & hit_m1 |=> pready && prdata == {24'h00_0000, $past(p1_mask_reg)})
    else $error("port 1 mask read wrong");

  a_p2_mask_read: assert property (
    rd_setup & hit_m2 |=> pready && prdata == {24'h00_0000, $past(p2_mask_reg)})
    else $error("port 2 mask read wrong");

  a_p3_mask_write: assert property (
    wr & hit_m3 |=> p3_mask_reg == $past(pwdata[7:0]))
    else $error("port 3 mask not written");

  a_p5_mask_write: assert property (
    wr & hit_m5 |=> p5_mask_reg == $past(pwdata[7:0]))
    else $error("port 5 mask not written");

  // a mid-run reset must leave the outputs as idle as power-up does
  a_reset_outputs: assert property (@(posedge pclk) disable iff (1'b0)
    $rose(presetn) |-> prdata == 32'h0000_0000 && !pready && !pslverr && !irq
                       && p1_mask == 8'h00 && p2_mask == 8'h00 && status_reg == 16'h0000)
    else $error("outputs not idle after reset");

  // status: an event always lands, even against a clear in the same cycle
  a_event_sets_status: assert property (
    |chg_set |=> (status_reg & $past(chg_set)) == $past(chg_set))
    else $error("pin change did not set its status bit");

  a_status_sticky: assert property (
    !(wr & hit_sts) |=> (status_reg & $past(status_reg)) == $past(status_reg))
    else $error("status bit dropped without a clear");

  a_status_clear: assert property (
    wr & hit_sts |=> (status_reg & $past(w1c & ~chg_set)) == 16'h0000)
    else $error("written one did not clear status");

  a_ien_write: assert property (
    wr & hit_ien |=> irq_en_reg == $past(pwdata[15:0]))
    else $error("interrupt enable not written");

  // bus protocol checks
  a_upper_bits_zero: assert property (
    rd_setup & ~hit_sts & ~hit_ien |=> prdata[31:8] == 24'h00_0000)
    else $error("byte register read has upper bits set");

  a_unmapped_error: assert property (
    setup & ~mapped |=> pready && pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  a_mapped_no_error: assert property (
    setup & mapped |=> pready && !pslverr)
    else $error("mapped access flagged as error");

  a_unmapped_write_drop: assert property (
    psel & penable & pready & pwrite & ~mapped |=>
      $stable({p3_level_reg, p5_level_reg, p1_mask_reg, p2_mask_reg, p3_mask_reg, p5_mask_reg}))
    else $error("unmapped write changed a register");

  a_ready_after_setup: assert property (
    pready |-> $past(setup))
    else $error("ready without a preceding setup cycle");

  // per pin: a masked or driven pin never raises its own status bit
  genvar gj;
  generate
    for (gj = 0; gj < gpb_pkg::EVT_W; gj++) begin : g_evt_chk
      a_masked_pin_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(status_reg[gj]) |-> $past(!mask16[gj]) && $past(!dir16[gj]))
        else $error("masked or output pin raised an event");
    end
  endgenerate

  c_p3_write:    cover property (wr & hit_p3l ##1 p3_drive.oe != 8'h00);
  c_bad_addr:    cover property (setup & ~mapped ##1 pslverr);
  c_event_irq:   cover property (|chg_set ##1 (|status_reg) ##1 irq);
  c_clear_event: cover property (wr & hit_sts & (|(chg_set & w1c)));
  c_p5_event:    cover property (|chg_set[15:8] ##1 (|status_reg[15:8]));

endmodule : gpb_bank

`default_nettype wire

// File: hw/gpb_pkg.sv
// shared constants and carrier types for the pin data and mask bank
package gpb_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PIN_W  = 8;
  localparam int unsigned EVT_W  = 16;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_P3_LEVEL = 8'h1A;
  localparam logic [7:0] IDX_P5_LEVEL = 8'h1B;
  localparam logic [7:0] IDX_P1_MASK  = 8'h1C;
  localparam logic [7:0] IDX_P2_MASK  = 8'h1D;
  localparam logic [7:0] IDX_P3_MASK  = 8'h1E;
  localparam logic [7:0] IDX_P5_MASK  = 8'h1F;
  localparam logic [7:0] IDX_STATUS   = 8'h20;
  localparam logic [7:0] IDX_IRQ_EN   = 8'h21;
  localparam logic [7:0] IDX_P3_DIR   = 8'h22;
  localparam logic [7:0] IDX_P5_DIR   = 8'h23;

  // event field layout: port 3 in the low byte, port 5 in the high byte
  localparam int unsigned EVT_P3_LSB = 0;
  localparam int unsigned EVT_P5_LSB = 8;

  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_HALF = 16'h0000;

  // cycles after reset before pin edges may raise events
  localparam int unsigned SETTLE_CYC = 3;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } gpb_drive_t;

endpackage : gpb_pkg

// File: tb/gpb_bank_tb.sv
// self-checking bench for the pin data and mask bank
`timescale 1ns/1ps
`default_nettype none

module gpb_bank_tb;
  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rd_err;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata, rd_data;
  logic [7:0]          p3_in, p5_in, p3_ext, p5_ext, p1_mask, p2_mask;
  gpb_pkg::gpb_drive_t p3_drive, p5_drive;
  int                  bad_count, samples_checked;

  gpb_bank uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .p3_in(p3_in), .p3_drive(p3_drive), .p5_in(p5_in), .p5_drive(p5_drive),
    .p1_mask(p1_mask), .p2_mask(p2_mask), .irq(irq));
  gpb_pins_model pins (.p3_drive(p3_drive), .p5_drive(p5_drive), .p3_ext(p3_ext), .p5_ext(p5_ext),
    .p3_in(p3_in), .p5_in(p5_in));

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  // holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle limit here: a hung slave is caught by the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string n);
    apb(1'b0, idx, 32'h0);
    chk(n, rd_data, exp);
  endtask : rd

  task automatic t_reset();
    for (int i = 0; i < 6; i++) rd(gpb_pkg::IDX_P3_LEVEL + 8'(i), 32'h0, "reset reg");
    chk("reset drives", {p3_drive, p5_drive}, 32'h0000_0000);
    chk("reset masks", {15'h0000, irq, p1_mask, p2_mask}, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_masks();
    logic [7:0] v[4] = '{8'h81, 8'h42, 8'h24, 8'h18};
    for (int i = 0; i < 4; i++) apb(1'b1, gpb_pkg::IDX_P1_MASK + 8'(i), {24'hFFFFFF, v[i]});
    for (int i = 0; i < 4; i++) rd(gpb_pkg::IDX_P1_MASK + 8'(i), {24'h0, v[i]}, "mask");
    chk("exported masks", {16'h0000, p1_mask, p2_mask}, 32'h0000_8142);
    $display("test masks done");
  endtask : t_masks

  task automatic t_unmapped();
    apb(1'b1, 8'h3F, 32'hFF);
    chk("write err", {31'h0000_0000, rd_err}, 32'h1);
    rd(8'h3F, 32'h0, "unmapped read");
    chk("read err", {31'h0000_0000, rd_err}, 32'h1);
    $display("test unmapped done");
  endtask : t_unmapped

  task automatic t_inputs();
    p3_ext <= 8'hA5;
    p5_ext <= 8'h3C;
    repeat (5) @(posedge pclk);
    rd(gpb_pkg::IDX_P3_LEVEL, 32'hA5, "p3 level");
    rd(gpb_pkg::IDX_P5_LEVEL, 32'h3C, "p5 level");
    $display("test inputs done");
  endtask : t_inputs

  task automatic t_outputs();
    apb(1'b1, gpb_pkg::IDX_P3_DIR, 32'hF0);
    apb(1'b1, gpb_pkg::IDX_P3_LEVEL, 32'h5A);
    apb(1'b1, gpb_pkg::IDX_P5_DIR, 32'hFF);
    apb(1'b1, gpb_pkg::IDX_P5_LEVEL, 32'hC3);
    @(posedge pclk);
    #1;
    chk("drives", {p3_drive, p5_drive}, 32'h5AF0C3FF);
    repeat (4) @(posedge pclk);
    rd(gpb_pkg::IDX_P3_LEVEL, 32'h55, "p3 mixed");
    rd(gpb_pkg::IDX_P5_LEVEL, 32'hC3, "p5 out");
    $display("test outputs done");
  endtask : t_outputs

  task automatic t_events();
    apb(1'b1, gpb_pkg::IDX_STATUS, 32'hFFFF);
    apb(1'b1, gpb_pkg::IDX_P3_MASK, 32'h01);
    apb(1'b1, gpb_pkg::IDX_IRQ_EN, 32'hFFFF);
    p3_ext <= p3_ext ^ 8'h03;
    repeat (6) @(posedge pclk);
    chk("irq raised", {31'h0000_0000, irq}, 32'h1);
    rd(gpb_pkg::IDX_STATUS, 32'h0002, "status");
    apb(1'b1, gpb_pkg::IDX_IRQ_EN, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq masked", {31'h0000_0000, irq}, 32'h0);
    apb(1'b1, gpb_pkg::IDX_STATUS, 32'h0002);
    rd(gpb_pkg::IDX_STATUS, 32'h0, "status cleared");
    // port 5 back to inputs: all eight pins toggle from C3 to 3C, mask 18 hides two of them
    apb(1'b1, gpb_pkg::IDX_P5_DIR, 32'h0);
    repeat (5) @(posedge pclk);
    rd(gpb_pkg::IDX_STATUS, 32'h0000_E700, "p5 events");
    $display("test events done");
  endtask : t_events

  task automatic t_midreset();
    p3_ext <= 8'h00;
    p5_ext <= 8'h00;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    $display("test mid reset done");
  endtask : t_midreset

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // generous bound: the sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    report_and_stop();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, p3_ext, p5_ext} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_masks();
    t_unmapped();
    t_inputs();
    t_outputs();
    t_events();
    t_midreset();
    report_and_stop();
  end
endmodule : gpb_bank_tb

`default_nettype wire

// File: tb/gpb_pins_model.sv
// board-side pins: external levels overridden where the block drives
`timescale 1ns/1ps
`default_nettype none

module gpb_pins_model (
  // drivers from the block
  input  wire gpb_pkg::gpb_drive_t p3_drive,
  input  wire gpb_pkg::gpb_drive_t p5_drive,
  // levels set by the board
  input  wire logic [7:0]          p3_ext,
  input  wire logic [7:0]          p5_ext,
  // sensed pin levels
  output logic      [7:0]          p3_in,
  output logic      [7:0]          p5_in
);
  // a driven pin shows the block's level, so releasing it to input gives a real edge
  assign p3_in = (p3_drive.oe & p3_drive.out) | (~p3_drive.oe & p3_ext);
  assign p5_in = (p5_drive.oe & p5_drive.out) | (~p5_drive.oe & p5_ext);
endmodule : gpb_pins_model

`default_nettype wire
